// ===== tcc_defs.vh
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// register addresses on the plain port
`define TCC_ADDR_W 3
`define TCC_A_CNT_LO 3'h0
`define TCC_A_CNT_HI 3'h1
`define TCC_A_CAP_LO 3'h2
`define TCC_A_CAP_HI 3'h3
`define TCC_A_CTRLB 3'h4
`define TCC_A_FLAGS 3'h5
`define TCC_A_IMASK 3'h6
`define TCC_A_CMPEXT 3'h7

// control_b fields
`define TCC_CB_NF 7
`define TCC_CB_EDGE 6
`define TCC_CB_WGM 4
`define TCC_CB_CS_HI 2
`define TCC_CB_CS_LO 0
`define TCC_CB_WMASK 8'hD7

// clock select codes
`define TCC_CS_STOP 3'h0
`define TCC_CS_SYS 3'h1
`define TCC_CS_EXT_FALL 3'h6
`define TCC_CS_EXT_RISE 3'h7

// flag and mask bits
`define TCC_F_OVF 0
`define TCC_F_CAP 5
`define TCC_CMPEXT_SEL 0

`define TCC_CNT_MAX 16'hFFFF
`define TCC_CNT_ZERO 16'h0000
`define TCC_NF_LEN 4

`endif

// ===== tcc_timer16.v
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "tcc_defs.vh"

module tcc_timer16 #(
    parameter NF_LEN = `TCC_NF_LEN
) (
    input wire REF_CLK,
    input wire RST_N,
    input wire [`TCC_ADDR_W-1:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    input wire EXT_COUNT_PIN,
    input wire CAPTURE_PIN,
    input wire COMPARATOR_ONE_OUTPUT,
    input wire OVF_IRQ_ACK,
    input wire CAP_IRQ_ACK,
    output wire OVF_IRQ,
    output wire CAP_IRQ
);

    // ------------------------------------------------------------
    // two-flop synchroniser plus edge history
    // ------------------------------------------------------------
    reg [2:0] ext_s_r;
    reg [1:0] pin_s_r;
    reg [1:0] cmp_s_r;

    always @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            ext_s_r <= 3'h0;
            pin_s_r <= 2'h0;
            cmp_s_r <= 2'h0;
        end
        else
        begin
            ext_s_r <= {ext_s_r[1:0], EXT_COUNT_PIN};
            pin_s_r <= {pin_s_r[0], CAPTURE_PIN};
            cmp_s_r <= {cmp_s_r[0], COMPARATOR_ONE_OUTPUT};
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] control_b_r;
    reg [7:0] hold_r;
    reg [15:0] count_value_r;
    reg [15:0] capture_value_r;
    reg overflow_flag_r;
    reg capture_flag_r;
    reg ovf_irq_enable_r;
    reg capture_irq_enable_r;
    reg comparator_capture_select_r;

    wire [2:0] clock_select = control_b_r[`TCC_CB_CS_HI:`TCC_CB_CS_LO];
    wire waveform_mode_bit = control_b_r[`TCC_CB_WGM];
    wire noise_filter_enable = control_b_r[`TCC_CB_NF];
    wire capture_edge_select = control_b_r[`TCC_CB_EDGE];

    // ------------------------------------------------------------
    // clock select and external edge detector
    // ------------------------------------------------------------
    wire ext_rise = ext_s_r[1] & ~ext_s_r[2];
    wire ext_fall = ~ext_s_r[1] & ext_s_r[2];
    reg timer_clock_enable;

    always @*
    begin
        case (clock_select)
            `TCC_CS_SYS: timer_clock_enable = 1'b1;
            `TCC_CS_EXT_RISE: timer_clock_enable = ext_rise;
            `TCC_CS_EXT_FALL: timer_clock_enable = ext_fall;
            default: timer_clock_enable = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // capture source, noise filter and edge detector
    // ------------------------------------------------------------
    wire cap_src = comparator_capture_select_r ? cmp_s_r[1] : pin_s_r[1];
    reg [NF_LEN-1:0] nf_hist_r;
    reg nf_out_r;
    reg cap_prev_r;
    wire cap_top_mode = waveform_mode_bit;
    wire nf_all1 = &{nf_hist_r[NF_LEN-2:0], cap_src};
    wire nf_all0 = ~|{nf_hist_r[NF_LEN-2:0], cap_src};
    wire cap_level = noise_filter_enable ? nf_out_r : cap_src;
    wire cap_edge = capture_edge_select ? (cap_level & ~cap_prev_r)
                                        : (~cap_level & cap_prev_r);
    wire cap_trig = cap_edge & ~cap_top_mode;

    always @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            nf_hist_r <= {NF_LEN{1'b0}};
            nf_out_r <= 1'b0;
            cap_prev_r <= 1'b0;
        end
        else
        begin
            nf_hist_r <= {nf_hist_r[NF_LEN-2:0], cap_src};
            if (nf_all1)
                nf_out_r <= 1'b1;
            else if (nf_all0)
                nf_out_r <= 1'b0;
            cap_prev_r <= cap_level;
        end
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire wr_cnt_lo = WR && (ADDR == `TCC_A_CNT_LO);
    wire wr_cap_lo = WR && (ADDR == `TCC_A_CAP_LO) && cap_top_mode;
    wire wr_hi = WR && ((ADDR == `TCC_A_CNT_HI) || (ADDR == `TCC_A_CAP_HI));
    wire rd_cnt_lo = RD && (ADDR == `TCC_A_CNT_LO);
    wire rd_cap_lo = RD && (ADDR == `TCC_A_CAP_LO);
    wire wr_flags = WR && (ADDR == `TCC_A_FLAGS);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    wire top_hit = cap_top_mode && (count_value_r == capture_value_r);
    wire wrap = (count_value_r == `TCC_CNT_MAX);
    reg [15:0] count_nxt;
    reg ovf_evt;

    always @*
    begin
        count_nxt = count_value_r;
        ovf_evt = 1'b0;
        if (wr_cnt_lo)
            count_nxt = {hold_r, WDATA};
        else if (timer_clock_enable)
        begin
            if (top_hit)
                count_nxt = `TCC_CNT_ZERO;
            else
                count_nxt = count_value_r + 16'h0001;
            ovf_evt = wrap;
        end
    end

    always @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            control_b_r <= 8'h00;
            hold_r <= 8'h00;
            count_value_r <= 16'h0000;
            capture_value_r <= 16'h0000;
            overflow_flag_r <= 1'b0;
            capture_flag_r <= 1'b0;
            ovf_irq_enable_r <= 1'b0;
            capture_irq_enable_r <= 1'b0;
            comparator_capture_select_r <= 1'b0;
        end
        else
        begin
            count_value_r <= count_nxt;
            if (WR && ADDR == `TCC_A_CTRLB)
                control_b_r <= WDATA & `TCC_CB_WMASK;
            if (WR && ADDR == `TCC_A_IMASK)
            begin
                ovf_irq_enable_r <= WDATA[`TCC_F_OVF];
                capture_irq_enable_r <= WDATA[`TCC_F_CAP];
            end
            if (WR && ADDR == `TCC_A_CMPEXT)
                comparator_capture_select_r <= WDATA[`TCC_CMPEXT_SEL];
            // holding byte changes only on high writes and low reads
            if (wr_hi)
                hold_r <= WDATA;
            else if (rd_cnt_lo)
                hold_r <= count_value_r[15:8];
            else if (rd_cap_lo)
                hold_r <= capture_value_r[15:8];
            if (wr_cap_lo)
                capture_value_r <= {hold_r, WDATA};
            else if (cap_trig)
                capture_value_r <= count_value_r;
            // set beats clear
            if (ovf_evt)
                overflow_flag_r <= 1'b1;
            else if (OVF_IRQ_ACK || (wr_flags && WDATA[`TCC_F_OVF]))
                overflow_flag_r <= 1'b0;
            if (cap_trig)
                capture_flag_r <= 1'b1;
            else if (CAP_IRQ_ACK || (wr_flags && WDATA[`TCC_F_CAP]))
                capture_flag_r <= 1'b0;
        end
    end

    assign OVF_IRQ = overflow_flag_r & ovf_irq_enable_r;
    assign CAP_IRQ = capture_flag_r & capture_irq_enable_r;

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    always @(posedge REF_CLK)
    begin
        if (!RST_N)
            RDATA <= 8'h00;
        else if (RD)
        begin
            case (ADDR)
                `TCC_A_CNT_LO: RDATA <= count_value_r[7:0];
                `TCC_A_CNT_HI: RDATA <= hold_r;
                `TCC_A_CAP_LO: RDATA <= capture_value_r[7:0];
                `TCC_A_CAP_HI: RDATA <= hold_r;
                `TCC_A_CTRLB: RDATA <= control_b_r;
                `TCC_A_FLAGS: RDATA <= {2'h0, capture_flag_r, 4'h0, overflow_flag_r};
                `TCC_A_IMASK: RDATA <= {2'h0, capture_irq_enable_r, 4'h0, ovf_irq_enable_r};
                `TCC_A_CMPEXT: RDATA <= {7'h00, comparator_capture_select_r};
                default: RDATA <= 8'h00;
            endcase
        end
        else
            RDATA <= 8'h00;
    end

endmodule // tcc_timer16

// ===== tcc_timer16_sva.sv
`timescale 1ns/10ps
`include "tcc_defs.vh"
module tcc_timer16_sva (
    input wire REF_CLK,
    input wire RST_N,
    input wire [`TCC_ADDR_W-1:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [7:0] RDATA,
    input wire EXT_COUNT_PIN,
    input wire CAPTURE_PIN,
    input wire COMPARATOR_ONE_OUTPUT,
    input wire OVF_IRQ_ACK,
    input wire CAP_IRQ_ACK,
    input wire OVF_IRQ,
    input wire CAP_IRQ
);
    // --------------------------------------------------
    // shadow of clock select and quiet time on capture inputs
    // --------------------------------------------------
    reg [3:0] q_r;
    reg [2:0] cs_r;
    reg wgm_r, en_r, pin_r, cmp_r;
    wire run = cs_r == `TCC_CS_SYS && !wgm_r;
    wire stop = cs_r < `TCC_CS_EXT_FALL && cs_r != `TCC_CS_SYS;
    always @(posedge REF_CLK)
    begin
        pin_r <= CAPTURE_PIN;
        cmp_r <= COMPARATOR_ONE_OUTPUT;
        if (!RST_N || WR || CAPTURE_PIN != pin_r || COMPARATOR_ONE_OUTPUT != cmp_r)
            q_r <= 4'h0;
        else if (q_r != 4'hF)
            q_r <= q_r + 4'h1;
        if (!RST_N)
            {wgm_r, cs_r, en_r} <= 5'h00;
        else if (WR && ADDR == `TCC_A_CTRLB)
            {wgm_r, cs_r} <= {WDATA[`TCC_CB_WGM], WDATA[2:0]};
        else if (WR && ADDR == `TCC_A_IMASK)
            en_r <= WDATA[`TCC_F_CAP];
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    a_rd_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not idle");
    a_hold_read: assert property (WR && ADDR == `TCC_A_CNT_HI ##1 RD && ADDR == `TCC_A_CNT_HI
        |=> RDATA == $past(WDATA, 2)) else $error("high byte lost");
    a_hold_keep: assert property (WR && ADDR == `TCC_A_CNT_HI ##1 WR && ADDR == `TCC_A_CNT_LO
        ##1 RD && ADDR == `TCC_A_CNT_HI |=> RDATA == $past(WDATA, 3)) else $error("hold lost");
    a_cnt_stop: assert property (WR && ADDR == `TCC_A_CNT_LO && stop ##1 !WR
        ##1 RD && ADDR == `TCC_A_CNT_LO |=> RDATA == $past(WDATA, 3)) else $error("stopped moved");
    a_cnt_run: assert property (WR && ADDR == `TCC_A_CNT_LO && run ##1 !WR
        ##1 RD && ADDR == `TCC_A_CNT_LO |=> RDATA == $past(WDATA, 3) + 8'h01) else $error("no count");
    a_cap_mask: assert property (!en_r |-> !CAP_IRQ)
        else $error("capture irq unmasked");
    a_cap_quiet: assert property ($rose(CAP_IRQ) |-> q_r < 4'hC)
        else $error("capture without edge");
    a_cap_w1c: assert property (WR && ADDR == `TCC_A_FLAGS && WDATA[`TCC_F_CAP] && q_r == 4'hF
        |=> !CAP_IRQ) else $error("flag not cleared");
    a_cap_ack: assert property (CAP_IRQ_ACK && q_r == 4'hF |=> !CAP_IRQ)
        else $error("ack ignored");
    c_cap: cover property ($rose(CAP_IRQ));
    c_ovf: cover property ($rose(OVF_IRQ));
    c_run: cover property (WR && run);
endmodule // tcc_timer16_sva
bind tcc_timer16 tcc_timer16_sva i_tcc_timer16_sva (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EXT_COUNT_PIN(EXT_COUNT_PIN),
    .CAPTURE_PIN(CAPTURE_PIN), .COMPARATOR_ONE_OUTPUT(COMPARATOR_ONE_OUTPUT),
    .OVF_IRQ_ACK(OVF_IRQ_ACK), .CAP_IRQ_ACK(CAP_IRQ_ACK), .OVF_IRQ(OVF_IRQ), .CAP_IRQ(CAP_IRQ));

// ===== tcc_ext_src.sv
`timescale 1ns/10ps
module tcc_ext_src (
    input wire clk,
    input wire go,
    output reg pin = 1'b0
);
    // --------------------------------------------------
    // one pulse per go, high for three cycles, then low for at least four
    // --------------------------------------------------
    reg [2:0] ph_r = 3'h0;
    always @(posedge clk)
    begin
        if (go && ph_r == 3'h0)
            ph_r <= 3'h6;
        else if (ph_r != 3'h0)
            ph_r <= ph_r - 3'h1;
        pin <= ph_r > 3'h3;
    end
endmodule // tcc_ext_src

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
    reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pend = 1'b0;
    reg go = 1'b0, cap = 1'b0, cmp = 1'b0, oack = 1'b0, cack = 1'b0;
    reg [2:0] addr = 3'h0;
    reg [7:0] wdata = 8'h00, pexp = 8'h00;
    wire [7:0] rdata;
    wire ext, ovf_irq, cap_irq;
    integer fail_count = 0, n_compared = 0, j, k;
    // --------------------------------------------------
    // bus tasks and main sequence
    // --------------------------------------------------
    tcc_timer16 i_tcc_timer16 (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .EXT_COUNT_PIN(ext), .CAPTURE_PIN(cap),
        .COMPARATOR_ONE_OUTPUT(cmp), .OVF_IRQ_ACK(oack), .CAP_IRQ_ACK(cack),
        .OVF_IRQ(ovf_irq), .CAP_IRQ(cap_irq));
    tcc_ext_src i_tcc_ext_src (.clk(clk), .go(go), .pin(ext));
    initial forever #2 clk = ~clk;
    task check(input [7:0] s, input [7:0] e);
    begin
        n_compared = n_compared + 1;
        if (s !== e)
        begin
            fail_count = fail_count + 1;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    end
    endtask
    task op(input [1:0] s, input [2:0] a, input [7:0] d);
    begin
        wr <= s[1];
        rd <= s[0];
        addr <= a;
        wdata <= d;
        @(posedge clk);
        if (pend)
            check(rdata, pexp);
        pend = s[0];
        pexp = d;
    end
    endtask
    task w(input [2:0] a, input [7:0] d);
        op(2'b10, a, d);
    endtask
    task r(input [2:0] a, input [7:0] e);
        op(2'b01, a, e);
    endtask
    task idle(input integer n);
        integer m;
        for (m = 0; m < n; m = m + 1)
            op(2'b00, 3'h0, 8'h00);
    endtask
    task ci(input e);
        check({7'h00, cap_irq}, {7'h00, e});
    endtask
    task wrap_up;
    begin
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    initial
    begin
        #40000;
        fail_count = fail_count + 1;
        wrap_up;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        w(3'h1, 8'h12);
        w(3'h0, 8'h34);
        r(3'h1, 8'h12);
        r(3'h0, 8'h34);
        r(3'h1, 8'h12);
        for (j = 0; j < 6; j = j + 1)
        begin
            w(3'h4, j[7:0]);
            w(3'h0, 8'h40);
            idle(1);
            r(3'h0, (j == 1) ? 8'h41 : 8'h40);
        end
        w(3'h1, 8'hFF);
        w(3'h0, 8'hFF);
        w(3'h4, 8'h01);
        w(3'h4, 8'h00);
        r(3'h0, 8'h00);
        r(3'h5, 8'h01);
        w(3'h6, 8'h01);
        idle(1);
        check({7'h00, ovf_irq}, 8'h01);
        oack <= 1'b1;
        idle(1);
        oack <= 1'b0;
        idle(1);
        check({7'h00, ovf_irq}, 8'h00);
        for (j = 7; j > 5; j = j - 1)
        begin
            w(3'h4, j[7:0]);
            w(3'h1, 8'h00);
            r(3'h1, 8'h00);
            w(3'h0, 8'h00);
            for (k = 0; k < 5; k = k + 1)
            begin
                go <= 1'b1;
                idle(1);
                go <= 1'b0;
                idle(7);
            end
            r(3'h0, 8'h05);
        end
        w(3'h1, 8'hAB);
        w(3'h0, 8'hCD);
        w(3'h6, 8'h20);
        w(3'h4, 8'h40);
        cap <= 1'b1;
        idle(12);
        ci(1'b1);
        r(3'h2, 8'hCD);
        r(3'h3, 8'hAB);
        idle(16);
        w(3'h5, 8'h20);
        idle(1);
        ci(1'b0);
        cap <= 1'b0;
        idle(12);
        ci(1'b0);
        w(3'h4, 8'h80);
        w(3'h0, 8'hEE);
        cap <= 1'b1;
        idle(2);
        cap <= 1'b0;
        idle(12);
        ci(1'b0);
        cap <= 1'b1;
        idle(8);
        cap <= 1'b0;
        idle(14);
        ci(1'b1);
        r(3'h2, 8'hEE);
        w(3'h7, 8'h01);
        idle(12);
        w(3'h5, 8'h20);
        idle(1);
        ci(1'b0);
        cmp <= 1'b1;
        idle(12);
        cmp <= 1'b0;
        idle(16);
        ci(1'b1);
        cack <= 1'b1;
        idle(1);
        cack <= 1'b0;
        idle(1);
        ci(1'b0);
        w(3'h4, 8'h10);
        w(3'h3, 8'h00);
        w(3'h2, 8'h05);
        r(3'h2, 8'h05);
        w(3'h1, 8'h00);
        w(3'h0, 8'h03);
        w(3'h4, 8'h11);
        idle(2);
        r(3'h0, 8'h05);
        r(3'h0, 8'h00);
        w(3'h4, 8'h10);
        cmp <= 1'b1;
        idle(12);
        cmp <= 1'b0;
        idle(12);
        ci(1'b0);
        w(3'h4, 8'h00);
        w(3'h2, 8'h77);
        r(3'h2, 8'h05);
        idle(1);
        wrap_up;
    end
endmodule // testbench
